// *** rtl/spimsc_core.sv ***
// SPI master/slave core with AHB-Lite register slave
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module spimsc_core
    import spimsc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Power mode inputs
    input wire logic cpu_wait_in,
    input wire logic stop_shallow_in,
    input wire logic stop_deep_in,
    // Serial clock pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_out,
    // Data pins
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out,
    // Select pin, active low
    input wire logic select_n_in,
    output logic select_n_out,
    output logic select_n_oe_out,
    // Interrupt request
    output logic irq_out
);
    typedef enum logic [1:0] {SPIMSC_IDLE, SPIMSC_SHIFT, SPIMSC_TAIL} spimsc_state_t;

    logic [7:0] control_one_q, control_two_q, baud_select_q, match_high_q, match_low_q;
    logic [15:0] tx_buf_q, rx_buf_q, shift_q;
    logic rx_full_q, match_q, tx_empty_q, fault_q;
    logic wr_pend_q;
    logic [4:0] wr_addr_q, rd_addr_q;
    logic [31:0] hrdata_q;
    spimsc_state_t state_q;
    logic [SPIMSC_BITCNT_W-1:0] edge_cnt_q;
    logic [SPIMSC_DIVCNT_W-1:0] div_cnt_q;
    logic sclk_q, sample_q;
    logic [2:0] sck_sync_q, mosi_sync_q, miso_sync_q, ss_sync_q;
    logic sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
    logic rx_cap_q, status_read_q;

    wire en = control_one_q[SPIMSC_C1_SYSTEM_ENABLE];
    wire master_select = control_one_q[SPIMSC_C1_MASTER_SELECT];
    wire clock_polarity = control_one_q[SPIMSC_C1_CLOCK_POLARITY];
    wire clock_phase = control_one_q[SPIMSC_C1_CLOCK_PHASE];
    wire lsbf = control_one_q[SPIMSC_C1_LOW_BIT_FIRST];
    wire select_output_enable = control_one_q[SPIMSC_C1_SELECT_OUTPUT_ENABLE];
    wire wide = control_two_q[SPIMSC_C2_WORD_LENGTH_SELECT];
    wire fault_detect_enable = control_two_q[SPIMSC_C2_FAULT_DETECT_ENABLE];
    wire swai = control_two_q[SPIMSC_C2_STOP_IN_WAIT];
    wire bidir = control_two_q[SPIMSC_C2_SINGLE_WIRE_PIN_CONTROL];
    wire bidir_oe = control_two_q[SPIMSC_C2_BIDIR_OUTPUT_ENABLE];

    // Master clock generation halts in stop-in-wait and shallow stop
    wire hold_master = (cpu_wait_in && swai) || stop_shallow_in;

    function automatic logic [SPIMSC_DIVCNT_W-1:0] half_period(input logic [7:0] br);
        logic [3:0] pre;
        logic [8:0] div;
        pre = 4'({1'b0, br[SPIMSC_BR_PRESCALE_LSB +: 3]}) + 4'h1;
        div = 9'h002 << br[SPIMSC_BR_DIVIDER_LSB +: 3];
        // Reload for half a bit time of pre*div clocks; the tick cycle itself counts as one
        half_period = (SPIMSC_DIVCNT_W'(pre * div) >> 1) - SPIMSC_DIVCNT_W'(1);
    endfunction : half_period

    function automatic logic [15:0] word_of(input logic [15:0] hi_lo, input logic w);
        word_of = w ? hi_lo : {8'h00, hi_lo[7:0]};
    endfunction : word_of

    // AHB-Lite address phase capture
    wire ahb_go = hsel_in && hready_in && htrans_in[1];
    wire [15:0] data_word = word_of(rx_buf_q, wide);
    wire [15:0] match_word = word_of({match_high_q, match_low_q}, wide);
    wire [7:0] flag_byte = {rx_full_q, match_q, tx_empty_q, fault_q, 4'h0};

    function automatic logic [7:0] read_mux(input logic [4:0] a, input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] br, input logic [7:0] fl, input logic [15:0] d,
                                          input logic [15:0] m);
        unique case (a)
            SPIMSC_OFS_CONTROL_ONE: read_mux = c1;
            SPIMSC_OFS_CONTROL_TWO: read_mux = c2;
            SPIMSC_OFS_BAUD_SELECT: read_mux = br;
            SPIMSC_OFS_FLAG_REGISTER: read_mux = fl;
            SPIMSC_OFS_DATA_HIGH: read_mux = d[15:8];
            SPIMSC_OFS_DATA_LOW: read_mux = d[7:0];
            SPIMSC_OFS_MATCH_HIGH: read_mux = m[15:8];
            SPIMSC_OFS_MATCH_LOW: read_mux = m[7:0];
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 5'h00;
            rd_addr_q <= 5'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= ahb_go && hwrite_in && haddr_in[31:5] == 27'h0000000;
            wr_addr_q <= haddr_in[4:0];
            if (ahb_go && !hwrite_in && haddr_in[31:5] == 27'h0000000) begin
                hrdata_q <= {24'h000000, read_mux(haddr_in[4:0], control_one_q, control_two_q, baud_select_q,
                                                 flag_byte, data_word, {match_high_q, match_low_q})};
            end else begin
                hrdata_q <= 32'h0000_0000;
            end
            rd_addr_q <= (ahb_go && !hwrite_in) ? haddr_in[4:0] : 5'h1f;
        end
    end

    assign hrdata_out = hrdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    wire wr_c1 = wr_pend_q && wr_addr_q == SPIMSC_OFS_CONTROL_ONE;
    wire wr_dl = wr_pend_q && wr_addr_q == SPIMSC_OFS_DATA_LOW;
    wire wr_dh = wr_pend_q && wr_addr_q == SPIMSC_OFS_DATA_HIGH;
    // Receive buffer is released by a read of the low data byte after a flag read
    wire rd_dl = rd_addr_q == SPIMSC_OFS_DATA_LOW && status_read_q;

    // Configuration registers; deep stop returns all of them to reset values
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            control_one_q <= SPIMSC_RST_CONTROL_ONE;
            control_two_q <= SPIMSC_RST_CONTROL_TWO;
            baud_select_q <= SPIMSC_RST_BAUD_SELECT;
            match_high_q <= SPIMSC_RST_MATCH;
            match_low_q <= SPIMSC_RST_MATCH;
        end else if (stop_deep_in) begin
            control_one_q <= SPIMSC_RST_CONTROL_ONE;
            control_two_q <= SPIMSC_RST_CONTROL_TWO;
            baud_select_q <= SPIMSC_RST_BAUD_SELECT;
            match_high_q <= SPIMSC_RST_MATCH;
            match_low_q <= SPIMSC_RST_MATCH;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                SPIMSC_OFS_CONTROL_ONE: control_one_q <= hwdata_in[7:0];
                SPIMSC_OFS_CONTROL_TWO: control_two_q <= hwdata_in[7:0] & 8'hdb;
                SPIMSC_OFS_BAUD_SELECT: baud_select_q <= hwdata_in[7:0] & 8'h77;
                SPIMSC_OFS_MATCH_HIGH: match_high_q <= hwdata_in[7:0];
                SPIMSC_OFS_MATCH_LOW: match_low_q <= hwdata_in[7:0];
                default: ;
            endcase
        end
    end

    // Pin input synchronisers: three flops, change accepted when last two agree
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_sync_q <= 3'h0;
            mosi_sync_q <= 3'h0;
            miso_sync_q <= 3'h0;
            ss_sync_q <= 3'h7;
            sck_s_q <= 1'b0;
            mosi_s_q <= 1'b0;
            miso_s_q <= 1'b0;
            ss_s_q <= 1'b1;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], serial_clock_pin_in};
            mosi_sync_q <= {mosi_sync_q[1:0], mosi_in};
            miso_sync_q <= {miso_sync_q[1:0], miso_in};
            ss_sync_q <= {ss_sync_q[1:0], select_n_in};
            if (sck_sync_q[1] == sck_sync_q[2]) sck_s_q <= sck_sync_q[2];
            if (mosi_sync_q[1] == mosi_sync_q[2]) mosi_s_q <= mosi_sync_q[2];
            if (miso_sync_q[1] == miso_sync_q[2]) miso_s_q <= miso_sync_q[2];
            if (ss_sync_q[1] == ss_sync_q[2]) ss_s_q <= ss_sync_q[2];
        end
    end

    // Data input: bidirectional mode reads the shared pin
    wire master_din = bidir ? mosi_s_q : miso_s_q;
    wire slave_din = bidir ? miso_s_q : mosi_s_q;
    wire [4:0] nbits = wide ? 5'd16 : 5'd8;
    wire [4:0] last_edge = wide ? 5'd31 : 5'd15;
    wire out_bit = lsbf ? shift_q[0] : (wide ? shift_q[15] : shift_q[7]);

    function automatic logic [15:0] shift_in(input logic [15:0] s, input logic b, input logic l, input logic w);
        if (l) shift_in = w ? {b, s[15:1]} : {8'h00, b, s[7:1]};
        else shift_in = {s[14:0], b};
    endfunction : shift_in

    // Slave clock edges seen through the synchroniser, leading/trailing per polarity and phase
    logic sck_prev_q;
    wire sck_edge = sck_s_q != sck_prev_q;
    wire sck_lead = sck_edge && (sck_s_q != clock_polarity);
    wire slave_sel = !master_select && !ss_s_q && en;
    wire slave_sample = slave_sel && sck_edge && (sck_lead ^ clock_phase);
    wire slave_drive = slave_sel && sck_edge && !(sck_lead ^ clock_phase);
    wire mode_fault = master_select && fault_detect_enable && !select_output_enable && !ss_s_q && en;
    wire master_start = en && master_select && !tx_empty_q && state_q == SPIMSC_IDLE && !hold_master && !fault_q;
    wire div_tick = div_cnt_q == '0;
    wire master_tick = state_q != SPIMSC_IDLE && div_tick && !hold_master;

    // Serial engine
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= SPIMSC_IDLE;
            edge_cnt_q <= '0;
            div_cnt_q <= '0;
            sclk_q <= 1'b0;
            shift_q <= 16'h0000;
            sample_q <= 1'b0;
            sck_prev_q <= 1'b0;
            rx_cap_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s_q;
            rx_cap_q <= 1'b0;
            if (!en || stop_deep_in || mode_fault) begin
                state_q <= SPIMSC_IDLE;
                edge_cnt_q <= '0;
                sclk_q <= clock_polarity;
                if (!master_select && ss_s_q) shift_q <= tx_buf_q;
            end else if (master_select) begin
                if (master_start) begin
                    shift_q <= tx_buf_q;
                    state_q <= SPIMSC_SHIFT;
                    div_cnt_q <= half_period(baud_select_q);
                    edge_cnt_q <= '0;
                    sclk_q <= clock_polarity;
                end else if (state_q != SPIMSC_IDLE && !hold_master && !div_tick) begin
                    div_cnt_q <= div_cnt_q - 1'b1;
                end else if (master_tick) begin
                    div_cnt_q <= half_period(baud_select_q);
                    // Trailing half period closes the frame; phase 1 shifts its last bit in here
                    if (state_q == SPIMSC_TAIL) begin
                        if (clock_phase) shift_q <= shift_in(shift_q, sample_q, lsbf, wide);
                        state_q <= SPIMSC_IDLE;
                        rx_cap_q <= 1'b1;
                    end else begin
                        sclk_q <= !sclk_q;
                        edge_cnt_q <= edge_cnt_q + 1'b1;
                        // Sample on one edge, shift on the other, so the output never moves on a sample edge
                        if (edge_cnt_q[0] == clock_phase) sample_q <= master_din;
                        else if (edge_cnt_q != '0) shift_q <= shift_in(shift_q, sample_q, lsbf, wide);
                        if (edge_cnt_q == last_edge) state_q <= SPIMSC_TAIL;
                    end
                end
            end else begin
                // Slave shifts on external edges in every power mode but deep stop
                if (slave_sample) shift_q <= shift_in(shift_q, slave_din, lsbf, wide);
                if (slave_sample) begin
                    edge_cnt_q <= edge_cnt_q + 1'b1;
                    if (edge_cnt_q == nbits - 5'd1) begin
                        edge_cnt_q <= '0;
                        rx_cap_q <= 1'b1;
                    end
                end
                if (slave_drive && edge_cnt_q == '0 && clock_phase) shift_q <= tx_buf_q;
            end
        end
    end

    // Status flags; hardware set wins over software clear, except that a data-low write wins over the transmit-empty set
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_full_q <= 1'b0;
            match_q <= 1'b0;
            tx_empty_q <= 1'b1;
            fault_q <= 1'b0;
            rx_buf_q <= 16'h0000;
            tx_buf_q <= 16'h0000;
            status_read_q <= 1'b0;
        end else if (!en || stop_deep_in) begin
            rx_full_q <= 1'b0;
            match_q <= 1'b0;
            tx_empty_q <= 1'b1;
            fault_q <= 1'b0;
            status_read_q <= 1'b0;
        end else begin
            if (rd_addr_q == SPIMSC_OFS_FLAG_REGISTER) status_read_q <= 1'b1;
            else if (rd_dl || wr_c1) status_read_q <= 1'b0;
            if (wr_dh) tx_buf_q[15:8] <= hwdata_in[7:0];
            if (wr_dl) begin
                tx_buf_q[7:0] <= hwdata_in[7:0];
                tx_empty_q <= 1'b0;
            end else if (master_start || (slave_drive && edge_cnt_q == '0)) begin
                tx_empty_q <= 1'b1;
            end
            if (rx_cap_q) begin
                rx_buf_q <= word_of(shift_q, wide);
                rx_full_q <= 1'b1;
                match_q <= word_of(shift_q, wide) == match_word;
            end else if (rd_dl) begin
                rx_full_q <= 1'b0;
            end
            if (mode_fault) fault_q <= 1'b1;
            else if (wr_c1 && status_read_q) fault_q <= 1'b0;
        end
    end

    // Pin drivers, all from flops
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe_out <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe_out <= 1'b0;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
            select_n_out <= 1'b1;
            select_n_oe_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            serial_clock_pin_out <= state_q == SPIMSC_IDLE ? clock_polarity : sclk_q;
            serial_clock_pin_oe_out <= en && master_select;
            mosi_out <= out_bit;
            mosi_oe_out <= en && master_select && (!bidir || bidir_oe);
            miso_out <= out_bit;
            miso_oe_out <= en && !master_select && !ss_s_q && (!bidir || bidir_oe);
            select_n_out <= state_q == SPIMSC_IDLE;
            select_n_oe_out <= en && master_select && fault_detect_enable && select_output_enable;
            irq_out <= (control_one_q[SPIMSC_C1_RX_FAULT_IRQ_ENABLE] && (rx_full_q || fault_q))
                || (control_one_q[SPIMSC_C1_TX_EMPTY_IRQ_ENABLE] && tx_empty_q && en)
                || (control_two_q[SPIMSC_C2_MATCH_IRQ_ENABLE] && match_q);
        end
    end
endmodule : spimsc_core
`default_nettype wire

// *** rtl/spimsc_pkg.sv ***
// Constants for the SPI master/slave core
// Behaviour
// - Wait mode with stop_in_wait clear behaves exactly like run mode.
// - Wait with stop_in_wait set stops clock generation; master freezes, resumes later.
// - Slave in wait with stop_in_wait set keeps shifting the current word.
// - Shallow stop: master pauses and resumes, slave keeps shifting.
// - Deeper stop disables block; all registers return to reset values on wake; here the transmit and receive data buffers keep their contents.
// - Only the master starts transfers; a slave waits for master clock edges.
// - Each transfer exchanges master and slave shift register contents simultaneously.
// - Serial clock pin is output as master, clock input as slave.
// - Slave responds only while select is low; master drives select low.
// - Written transmit word is held and loaded into shifter when transfer starts; here a phase 0 slave loads it only while disabled with select high.
// - After 8 or 16 bits, received word moves into receive buffer.
// - Master drives MOSI from shifter and samples MISO.
// - Slave drives MISO from shifter and samples MOSI on incoming clock.
// - With system_enable 0 all four pins are released.
// - Match flag sets when receive buffer equals the match value.
// - Shift order MSB-first or LSB-first per low_bit_first.
// - Master with fault detect flags mode fault when select is driven low externally.
// - Polarity 0 idles clock low; polarity 1 idles clock high.
// - Phase 0 first edge mid first bit; phase 1 first edge at bit start.
// - Clearing system_enable forces idle and clears all status bits; here transmit empty is set, not cleared.
// - With interrupt enable 1, request while receive-full or mode-fault is set.
package spimsc_pkg;
    localparam logic [4:0] SPIMSC_OFS_CONTROL_ONE = 5'h00;
    localparam logic [4:0] SPIMSC_OFS_CONTROL_TWO = 5'h04;
    localparam logic [4:0] SPIMSC_OFS_BAUD_SELECT = 5'h08;
    localparam logic [4:0] SPIMSC_OFS_FLAG_REGISTER = 5'h0c;
    localparam logic [4:0] SPIMSC_OFS_DATA_HIGH = 5'h10;
    localparam logic [4:0] SPIMSC_OFS_DATA_LOW = 5'h14;
    localparam logic [4:0] SPIMSC_OFS_MATCH_HIGH = 5'h18;
    localparam logic [4:0] SPIMSC_OFS_MATCH_LOW = 5'h1c;
    localparam logic [7:0] SPIMSC_RST_CONTROL_ONE = 8'h04;
    localparam logic [7:0] SPIMSC_RST_CONTROL_TWO = 8'h00;
    localparam logic [7:0] SPIMSC_RST_BAUD_SELECT = 8'h00;
    localparam logic [7:0] SPIMSC_RST_MATCH = 8'h00;
    // control_one fields
    localparam int SPIMSC_C1_RX_FAULT_IRQ_ENABLE = 7;
    localparam int SPIMSC_C1_SYSTEM_ENABLE = 6;
    localparam int SPIMSC_C1_TX_EMPTY_IRQ_ENABLE = 5;
    localparam int SPIMSC_C1_MASTER_SELECT = 4;
    localparam int SPIMSC_C1_CLOCK_POLARITY = 3;
    localparam int SPIMSC_C1_CLOCK_PHASE = 2;
    localparam int SPIMSC_C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int SPIMSC_C1_LOW_BIT_FIRST = 0;
    // control_two fields
    localparam int SPIMSC_C2_MATCH_IRQ_ENABLE = 7;
    localparam int SPIMSC_C2_WORD_LENGTH_SELECT = 6;
    localparam int SPIMSC_C2_FAULT_DETECT_ENABLE = 4;
    localparam int SPIMSC_C2_BIDIR_OUTPUT_ENABLE = 3;
    localparam int SPIMSC_C2_STOP_IN_WAIT = 1;
    localparam int SPIMSC_C2_SINGLE_WIRE_PIN_CONTROL = 0;
    // baud_select fields
    localparam int SPIMSC_BR_PRESCALE_LSB = 4;
    localparam int SPIMSC_BR_DIVIDER_LSB = 0;
    // flag_register fields
    localparam int SPIMSC_FL_RECEIVE_FULL = 7;
    localparam int SPIMSC_FL_MATCH = 6;
    localparam int SPIMSC_FL_TRANSMIT_EMPTY = 5;
    localparam int SPIMSC_FL_MASTER_FAULT = 4;
    localparam logic [1:0] SPIMSC_HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] SPIMSC_HSIZE_WORD = 3'b010;
    localparam int SPIMSC_BITCNT_W = 5;
    localparam int SPIMSC_DIVCNT_W = 12;
endpackage : spimsc_pkg

// *** testbench/spimsc_checker.sv ***
// Port assertions for the SPI master/slave core
`timescale 1ns/10ps
`default_nettype none
module spimsc_checker (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic select_n_out,
    input wire logic select_n_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [5:0] edge_cnt_q;
    logic clk_prev_q;
    // Counts serial clock edges inside one frame
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            edge_cnt_q <= 6'h00;
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= serial_clock_pin_out;
            if (select_n_out) edge_cnt_q <= 6'h00;
            else if (clk_prev_q != serial_clock_pin_out) edge_cnt_q <= edge_cnt_q + 6'h01;
        end
    end
    a_bus_always_okay: assert property (hreadyout_out && !hresp_out) else $error("bus answer not ready okay");
    a_master_no_miso: assert property (serial_clock_pin_oe_out |-> !miso_oe_out)
        else $error("master drives miso");
    a_mosi_as_master: assert property (mosi_oe_out |-> serial_clock_pin_oe_out)
        else $error("mosi driven outside master mode");
    a_slave_no_drive: assert property (miso_oe_out |-> !mosi_oe_out && !serial_clock_pin_oe_out)
        else $error("slave drives mosi or clock");
    a_select_as_master: assert property (select_n_oe_out |-> serial_clock_pin_oe_out)
        else $error("select driven outside master mode");
    a_idle_clock_still: assert property (serial_clock_pin_oe_out && $past(serial_clock_pin_oe_out) && select_n_out
        && $past(select_n_out) |-> $stable(serial_clock_pin_out)) else $error("clock moves between frames");
    a_frame_bounded: assert property ($fell(select_n_out) |-> ##[1:600] select_n_out)
        else $error("frame does not end");
    a_word_edges: assert property ($rose(select_n_out) |-> edge_cnt_q == 6'h10 || edge_cnt_q == 6'h20)
        else $error("frame edge count wrong");
    c_frame_start: cover property ($fell(select_n_out) && serial_clock_pin_oe_out);
    c_byte_frame: cover property ($rose(select_n_out) && edge_cnt_q == 6'h10);
    c_pins_released: cover property ($fell(serial_clock_pin_oe_out));
endmodule : spimsc_checker
bind spimsc_core spimsc_checker i_spimsc_checker (.core_clk_in, .reset_n_in, .hreadyout_out, .hresp_out,
    .serial_clock_pin_out, .serial_clock_pin_oe_out, .mosi_oe_out, .miso_oe_out, .select_n_out, .select_n_oe_out);
`default_nettype wire

// *** testbench/spimsc_partner.sv ***
// Behavioural external SPI slave, idle-low clock, first edge mid bit, most significant bit first
`timescale 1ns/10ps
`default_nettype none
module spimsc_partner (
    // Serial side
    input wire logic sck_in,
    input wire logic select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    // Bench side
    input wire logic [7:0] tx_in,
    output logic [7:0] rx_out
);
    logic [7:0] shift_q = 8'h00;
    logic last_q = 1'b0;
    initial rx_out = 8'h00;
    // Loads only when selected, then moves only on edges from the master
    always @(negedge select_n_in) shift_q = tx_in;
    always @(posedge sck_in) if (!select_n_in) rx_out = {rx_out[6:0], mosi_in};
    always @(negedge sck_in) if (!select_n_in) shift_q = {shift_q[6:0], 1'b0};
    always @(posedge select_n_in) last_q = shift_q[7];
    // Released line shows the inverse of the last bit so stale data cannot pass
    assign miso_out = select_n_in ? ~last_q : shift_q[7];
endmodule : spimsc_partner
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the SPI master/slave core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import spimsc_pkg::*;
    logic core_clk_in = 1'b0, reset_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, stop_deep_in = 1'b0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic [7:0] ptx = 8'h00;
    int n_mismatch = 0, check_count = 0, cycles = 0;
    wire [31:0] hrdata_out;
    wire hreadyout_out, hresp_out, irq_out, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_out, sel_oe;
    wire p_miso;
    wire [7:0] p_rx;
    wire sck_line = sck_oe ? sck_out : 1'b0;
    wire sel_line = sel_oe ? sel_out : 1'b1;
    wire mosi_line = mosi_oe ? mosi_out : ~mosi_out;
    wire miso_line = miso_oe ? miso_out : p_miso;
    spimsc_core i_spimsc_core (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(SPIMSC_HSIZE_WORD),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .cpu_wait_in(1'b0), .stop_shallow_in(1'b0), .stop_deep_in(stop_deep_in),
        .serial_clock_pin_in(sck_line), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_out(sck_oe),
        .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe), .miso_in(miso_line), .miso_out(miso_out),
        .miso_oe_out(miso_oe), .select_n_in(sel_line), .select_n_out(sel_out), .select_n_oe_out(sel_oe),
        .irq_out(irq_out));
    spimsc_partner i_spimsc_partner (.sck_in(sck_line), .select_n_in(sel_line), .mosi_in(mosi_line),
        .miso_out(p_miso), .tx_in(ptx), .rx_out(p_rx));
    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check_eq(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check_eq
    task automatic ahb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge core_clk_in);
        hsel_in <= 1'b1;
        htrans_in <= SPIMSC_HTRANS_NONSEQ;
        haddr_in <= {26'h0, a};
        hwrite_in <= w;
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, d};
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        r = hrdata_out[7:0];
    endtask : ahb
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        ahb(1'b1, {1'b0, a}, d, r);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [7:0] r);
        ahb(1'b0, {1'b0, a}, 8'h00, r);
    endtask : rd
    // One master word: queue it, poll for receive full, read it back and clear
    task automatic xfer(input logic [7:0] c1, dtx, exp_rx, exp_prx, fmask, fexp);
        logic [7:0] r;
        int n;
        wr(SPIMSC_OFS_CONTROL_ONE, c1);
        rd(SPIMSC_OFS_FLAG_REGISTER, r);
        check_eq("transmit empty", 8'h20, r & 8'h20);
        wr(SPIMSC_OFS_DATA_HIGH, 8'h00);
        wr(SPIMSC_OFS_DATA_LOW, dtx);
        n = 0;
        r = 8'h00;
        while (r[SPIMSC_FL_RECEIVE_FULL] !== 1'b1 && n < 300) begin
            rd(SPIMSC_OFS_FLAG_REGISTER, r);
            n++;
        end
        check_eq("flags full", fexp, r & fmask);
        check_eq("irq full", 8'h01, {7'h0, irq_out});
        rd(SPIMSC_OFS_DATA_LOW, r);
        check_eq("rx word", exp_rx, r);
        check_eq("partner word", exp_prx, p_rx);
        rd(SPIMSC_OFS_FLAG_REGISTER, r);
        check_eq("flags cleared", 8'h20, r & 8'ha0);
        check_eq("irq cleared", 8'h00, {7'h0, irq_out});
    endtask : xfer
    task automatic test_reset_values;
        logic [7:0] r;
        rd(SPIMSC_OFS_CONTROL_ONE, r);
        check_eq("control_one", SPIMSC_RST_CONTROL_ONE, r);
        rd(SPIMSC_OFS_CONTROL_TWO, r);
        check_eq("control_two", SPIMSC_RST_CONTROL_TWO, r);
        rd(SPIMSC_OFS_BAUD_SELECT, r);
        check_eq("baud_select", SPIMSC_RST_BAUD_SELECT, r);
        rd(SPIMSC_OFS_MATCH_LOW, r);
        check_eq("match_low", SPIMSC_RST_MATCH, r);
        rd(SPIMSC_OFS_FLAG_REGISTER, r);
        check_eq("flag_register", 8'h20, r);
        ahb(1'b1, 6'h20, 8'hff, r);
        ahb(1'b0, 6'h20, 8'h00, r);
        check_eq("unmapped", 8'h00, r);
        $display("test_reset_values done");
    endtask : test_reset_values
    task automatic test_master_msb;
        wr(SPIMSC_OFS_MATCH_HIGH, 8'h00);
        wr(SPIMSC_OFS_MATCH_LOW, 8'h3c);
        wr(SPIMSC_OFS_BAUD_SELECT, 8'h23);
        wr(SPIMSC_OFS_CONTROL_TWO, 8'h10);
        ptx = 8'h3c;
        xfer(8'hd2, 8'ha5, 8'h3c, 8'ha5, 8'he0, 8'he0);
        $display("test_master_msb done");
    endtask : test_master_msb
    task automatic test_master_lsb;
        wr(SPIMSC_OFS_BAUD_SELECT, 8'h12);
        ptx = 8'h35;
        xfer(8'hd3, 8'h01, 8'hac, 8'h80, 8'ha0, 8'ha0);
        $display("test_master_lsb done");
    endtask : test_master_lsb
    task automatic test_disable_deep;
        logic [7:0] r;
        wr(SPIMSC_OFS_CONTROL_ONE, 8'h00);
        rd(SPIMSC_OFS_FLAG_REGISTER, r);
        check_eq("flags disabled", 8'h20, r);
        check_eq("pins released", 8'h00, {4'h0, sck_oe, mosi_oe, miso_oe, sel_oe});
        @(posedge core_clk_in);
        stop_deep_in <= 1'b1;
        @(posedge core_clk_in);
        stop_deep_in <= 1'b0;
        rd(SPIMSC_OFS_CONTROL_TWO, r);
        check_eq("control_two after stop", SPIMSC_RST_CONTROL_TWO, r);
        $display("test_disable_deep done");
    endtask : test_disable_deep
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        test_reset_values();
        test_master_msb();
        test_master_lsb();
        test_disable_deep();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
